/* src/pfm_pkg.sv */
// Package: register map, field layout and reset values of the pin mux
package pfm_pkg;
    localparam logic [7:0] ADDR_P1_MODE_LOW  = 8'ha2;
    localparam logic [7:0] ADDR_P1_MODE_HIGH = 8'ha3;
    localparam logic [7:0] ADDR_P3_MODE_LOW  = 8'ha4;
    localparam logic [7:0] ADDR_P3_MODE_HIGH = 8'ha5;
    localparam logic [7:0] ADDR_PWM_ROUTE_A  = 8'ha6;
    localparam logic [7:0] ADDR_CHAN_SELECT  = 8'hae;
    localparam logic [7:0] ADDR_P0_IN_ENABLE = 8'haf;
    localparam logic [7:0] ADDR_PWM_ROUTE_B  = 8'hb6;
    localparam logic [7:0] ADDR_PWM_ROUTE_C  = 8'hb7;

    localparam logic [7:0] RST_MODE_REG      = 8'h55;
    localparam logic [7:0] RST_ROUTE         = 8'h00;
    localparam logic [7:0] RST_P0_IN_ENABLE  = 8'hff;
    localparam logic [7:0] RST_CHAN_SELECT   = 8'hf0;

    localparam logic [1:0] MODE_ANALOG       = 2'h3;

    localparam int CHAN_NIB_MSB = 7;
    localparam int CHAN_NIB_LSB = 4;
    localparam int CHAN_TOP_BIT = 3;
    localparam int REF_SEL_BIT  = 2;
    localparam int SDA_SEL_BIT  = 7;
    localparam int SCL_SEL_BIT  = 6;

    // Analog converter input codes
    localparam logic [4:0] CH_BANDGAP  = 5'h0c;
    localparam logic [4:0] CH_GROUND   = 5'h0e;
    localparam logic [4:0] CH_SUPPLY_4 = 5'h0f;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfm_bus_s;

    // Per-pin output drive: enable plus value for ports 0, 1 and 3
    typedef struct packed {
        logic [7:0] p0_en;
        logic [7:0] p0_val;
        logic [7:0] p1_en;
        logic [7:0] p1_val;
        logic [7:0] p3_en;
        logic [7:0] p3_val;
    } pfm_drive_s;

    typedef struct packed {
        logic [4:0] channel;
        logic       ref_bandgap;
        logic [1:0] bandgap_level;
        logic       ext_valid;
        logic       bandgap;
        logic       ground;
        logic       supply_quarter;
    } pfm_adc_s;
endpackage

/* src/pfm_pin_mux.sv */
// Pin function, PWM routing and analog channel mux
//
// How it works
// - Port1 pins 0-3 have 2-bit modes, pin0 at bits 1:0, reset 01.
// - Port1 pins 4-7 have 2-bit modes in second register, reset 01.
// - Port1 mode 11 makes pins 0,1,3-7 analog; pin 2 stays digital.
// - Port3 pins 0-3 have 2-bit modes, same encoding, reset 01.
// - Port3 pins 4-7 have 2-bit modes in second register, reset 01.
// - Port3 mode 11 makes pins 0-4 analog; pins 5-7 never analog.
// - Route A bits 7-4 put PWM1 on P1.2, P0.6, P0.4, P0.2.
// - Route A bits 3,1 put ch0 negative on P3.6, P0.4; 2,0 positive.
// - Route B bits 7-4 put PWM4 on P3.6, P1.5, P0.4, P0.0.
// - Route B bits 3,2 put PWM3 on P3.4 and P1.0.
// - Route B bits 1,0 put PWM2 on P3.6 and P1.1.
// - Route C bits 5-3 put PWM6 on P1.3, P0.7, P0.3.
// - Route C bits 2-0 put PWM5 on P1.4, P0.6, P0.1.
// - Route C bit 7 picks I2C data pin: 0 P3.5, 1 P1.6.
// - Route C bit 6 picks I2C clock pin: 0 P1.3, 1 P0.2.
// - P0 input enables reset 1; cleared bit is analog except pin 6.
// - Channel is {bit 3, bits 7:4}; nibble resets 1111, top bit 0.
// - Codes 0-11 and 16-22 select external inputs on the listed port pins.
// - Code 12 bandgap, 14 ground, 15 supply/4; 13 and 23-31 reserved.
// - Bit 2 picks reference, bits 1:0 bandgap level; software avoids 1.22V.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps

module pfm_pin_mux
    import pfm_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire pfm_bus_s   bus_in,
    output logic [7:0]      rdata_out,
    input  wire logic [6:0] pwm_in,
    input  wire logic       pwm0_neg_in,
    input  wire logic       i2c_sda_oe_in,
    input  wire logic       i2c_sda_o_in,
    input  wire logic       i2c_scl_oe_in,
    input  wire logic       i2c_scl_o_in,
    output pfm_drive_s      drive_out,
    output logic [15:0]     p1_mode_out,
    output logic [15:0]     p3_mode_out,
    output logic [7:0]      p0_din_enable_out,
    output logic [7:0]      p0_analog_out,
    output logic [7:0]      p1_analog_out,
    output logic [7:0]      p3_analog_out,
    output pfm_adc_s        adc_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] p1_mode_low;
    logic [7:0] p1_mode_high;
    logic [7:0] p3_mode_low;
    logic [7:0] p3_mode_high;
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [7:0] route_c;
    logic [7:0] p0_in_enable;
    logic [7:0] chan_select;

    wire logic wr = bus_in.wr;
    wire logic [7:0] wd = bus_in.wdata;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            p1_mode_low  <= RST_MODE_REG;
            p1_mode_high <= RST_MODE_REG;
            p3_mode_low  <= RST_MODE_REG;
            p3_mode_high <= RST_MODE_REG;
            route_a      <= RST_ROUTE;
            route_b      <= RST_ROUTE;
            route_c      <= RST_ROUTE;
            p0_in_enable <= RST_P0_IN_ENABLE;
            chan_select  <= RST_CHAN_SELECT;
        end else if (wr) begin
            unique case (bus_in.addr)
                ADDR_P1_MODE_LOW:  p1_mode_low  <= wd;
                ADDR_P1_MODE_HIGH: p1_mode_high <= wd;
                ADDR_P3_MODE_LOW:  p3_mode_low  <= wd;
                ADDR_P3_MODE_HIGH: p3_mode_high <= wd;
                ADDR_PWM_ROUTE_A:  route_a      <= wd;
                ADDR_PWM_ROUTE_B:  route_b      <= wd;
                ADDR_PWM_ROUTE_C:  route_c      <= wd;
                ADDR_P0_IN_ENABLE: p0_in_enable <= wd;
                ADDR_CHAN_SELECT:  chan_select  <= wd;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] read_mux;
    always_comb begin
        unique case (bus_in.addr)
            ADDR_P1_MODE_LOW:  read_mux = p1_mode_low;
            ADDR_P1_MODE_HIGH: read_mux = p1_mode_high;
            ADDR_P3_MODE_LOW:  read_mux = p3_mode_low;
            ADDR_P3_MODE_HIGH: read_mux = p3_mode_high;
            ADDR_PWM_ROUTE_A:  read_mux = route_a;
            ADDR_PWM_ROUTE_B:  read_mux = route_b;
            ADDR_PWM_ROUTE_C:  read_mux = route_c;
            ADDR_P0_IN_ENABLE: read_mux = p0_in_enable;
            ADDR_CHAN_SELECT:  read_mux = chan_select;
            default:           read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= bus_in.rd ? read_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Next-state values seen by the pin logic
    // ------------------------------------------------------------
    // Written value bypasses the register so outputs change on the
    // same edge that completes the write.
    wire logic hit_p1l = wr && bus_in.addr == ADDR_P1_MODE_LOW;
    wire logic hit_p1h = wr && bus_in.addr == ADDR_P1_MODE_HIGH;
    wire logic hit_p3l = wr && bus_in.addr == ADDR_P3_MODE_LOW;
    wire logic hit_p3h = wr && bus_in.addr == ADDR_P3_MODE_HIGH;
    wire logic hit_ra  = wr && bus_in.addr == ADDR_PWM_ROUTE_A;
    wire logic hit_rb  = wr && bus_in.addr == ADDR_PWM_ROUTE_B;
    wire logic hit_rc  = wr && bus_in.addr == ADDR_PWM_ROUTE_C;
    wire logic hit_die = wr && bus_in.addr == ADDR_P0_IN_ENABLE;
    wire logic hit_ch  = wr && bus_in.addr == ADDR_CHAN_SELECT;

    wire logic [7:0] n_p1l = hit_p1l ? wd : p1_mode_low;
    wire logic [7:0] n_p1h = hit_p1h ? wd : p1_mode_high;
    wire logic [7:0] n_p3l = hit_p3l ? wd : p3_mode_low;
    wire logic [7:0] n_p3h = hit_p3h ? wd : p3_mode_high;
    wire logic [7:0] n_ra  = hit_ra ? wd : route_a;
    wire logic [7:0] n_rb  = hit_rb ? wd : route_b;
    wire logic [7:0] n_rc  = hit_rc ? wd : route_c;
    wire logic [7:0] n_die = hit_die ? wd : p0_in_enable;
    wire logic [7:0] n_ch  = hit_ch ? wd : chan_select;

    // ------------------------------------------------------------
    // Analog pin roles
    // ------------------------------------------------------------
    wire logic [15:0] p1m = {n_p1h, n_p1l};
    wire logic [15:0] p3m = {n_p3h, n_p3l};
    logic [7:0] p1_is_mode3;
    logic [7:0] p3_is_mode3;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p1_is_mode3[i] = (p1m[2*i +: 2] == MODE_ANALOG);
            p3_is_mode3[i] = (p3m[2*i +: 2] == MODE_ANALOG);
        end
    end
    wire logic [7:0] next_p1_analog = p1_is_mode3 & 8'hfb;
    wire logic [7:0] next_p3_analog = p3_is_mode3 & 8'h1f;
    wire logic [7:0] next_p0_analog = ~n_die & 8'hbf;

    // ------------------------------------------------------------
    // Serial pin selects
    // ------------------------------------------------------------
    wire logic sda_alt    = n_rc[SDA_SEL_BIT];
    wire logic scl_alt    = n_rc[SCL_SEL_BIT];
    wire logic sda_on_p35 = !sda_alt && i2c_sda_oe_in;
    wire logic scl_on_p13 = !scl_alt && i2c_scl_oe_in;

    // ------------------------------------------------------------
    // Port0 routing, fixed priority on shared pins
    // ------------------------------------------------------------
    logic [7:0] p0_en;
    logic [7:0] p0_v;
    always_comb begin
        p0_en = 8'h00;
        p0_v  = 8'h00;
        // P0.0
        if (n_rb[4]) begin
            p0_en[0] = 1'b1;
            p0_v[0]  = pwm_in[4];
        end
        // P0.1
        if (n_rc[0]) begin
            p0_en[1] = 1'b1;
            p0_v[1]  = pwm_in[5];
        end
        // P0.2: I2C clock first, then PWM1
        if (scl_alt) begin
            p0_en[2] = i2c_scl_oe_in;
            p0_v[2]  = i2c_scl_o_in;
        end else if (n_ra[4]) begin
            p0_en[2] = 1'b1;
            p0_v[2]  = pwm_in[1];
        end
        // P0.3: ch0 positive over PWM6
        if (n_ra[0]) begin
            p0_en[3] = 1'b1;
            p0_v[3]  = pwm_in[0];
        end else if (n_rc[3]) begin
            p0_en[3] = 1'b1;
            p0_v[3]  = pwm_in[6];
        end
        // P0.4: ch0 negative, PWM1, PWM4 in that order
        if (n_ra[1]) begin
            p0_en[4] = 1'b1;
            p0_v[4]  = pwm0_neg_in;
        end else if (n_ra[5]) begin
            p0_en[4] = 1'b1;
            p0_v[4]  = pwm_in[1];
        end else if (n_rb[5]) begin
            p0_en[4] = 1'b1;
            p0_v[4]  = pwm_in[4];
        end
        // P0.6: PWM5 over PWM1
        if (n_rc[1]) begin
            p0_en[6] = 1'b1;
            p0_v[6]  = pwm_in[5];
        end else if (n_ra[6]) begin
            p0_en[6] = 1'b1;
            p0_v[6]  = pwm_in[1];
        end
        // P0.7
        if (n_rc[4]) begin
            p0_en[7] = 1'b1;
            p0_v[7]  = pwm_in[6];
        end
    end

    // ------------------------------------------------------------
    // Port1 routing
    // ------------------------------------------------------------
    logic [7:0] p1_en;
    logic [7:0] p1_v;
    always_comb begin
        p1_en = 8'h00;
        p1_v  = 8'h00;
        if (n_rb[2]) begin
            p1_en[0] = 1'b1;
            p1_v[0]  = pwm_in[3];
        end
        if (n_rb[0]) begin
            p1_en[1] = 1'b1;
            p1_v[1]  = pwm_in[2];
        end
        if (n_ra[7]) begin
            p1_en[2] = 1'b1;
            p1_v[2]  = pwm_in[1];
        end
        // P1.3: I2C clock default pin, else PWM6
        if (scl_on_p13) begin
            p1_en[3] = 1'b1;
            p1_v[3]  = i2c_scl_o_in;
        end else if (n_rc[5]) begin
            p1_en[3] = 1'b1;
            p1_v[3]  = pwm_in[6];
        end
        if (n_rc[2]) begin
            p1_en[4] = 1'b1;
            p1_v[4]  = pwm_in[5];
        end
        if (n_rb[6]) begin
            p1_en[5] = 1'b1;
            p1_v[5]  = pwm_in[4];
        end
        // P1.6 alternate I2C data pin
        if (sda_alt) begin
            p1_en[6] = i2c_sda_oe_in;
            p1_v[6]  = i2c_sda_o_in;
        end
    end

    // ------------------------------------------------------------
    // Port3 routing
    // ------------------------------------------------------------
    logic [7:0] p3_en;
    logic [7:0] p3_v;
    always_comb begin
        p3_en = 8'h00;
        p3_v  = 8'h00;
        if (n_rb[3]) begin
            p3_en[4] = 1'b1;
            p3_v[4]  = pwm_in[3];
        end
        // P3.5: I2C data default pin, else ch0 positive
        if (sda_on_p35) begin
            p3_en[5] = 1'b1;
            p3_v[5]  = i2c_sda_o_in;
        end else if (n_ra[2]) begin
            p3_en[5] = 1'b1;
            p3_v[5]  = pwm_in[0];
        end
        // P3.6: PWM2, ch0 negative, PWM4 in that order
        if (n_rb[1]) begin
            p3_en[6] = 1'b1;
            p3_v[6]  = pwm_in[2];
        end else if (n_ra[3]) begin
            p3_en[6] = 1'b1;
            p3_v[6]  = pwm0_neg_in;
        end else if (n_rb[7]) begin
            p3_en[6] = 1'b1;
            p3_v[6]  = pwm_in[4];
        end
    end

    // ------------------------------------------------------------
    // Analog channel decode
    // ------------------------------------------------------------
    wire logic [4:0] next_chan = {n_ch[CHAN_TOP_BIT],
                                  n_ch[CHAN_NIB_MSB:CHAN_NIB_LSB]};
    wire logic ext_low  = next_chan <= 5'h0b;
    wire logic ext_high = next_chan >= 5'h10 && next_chan <= 5'h16;
    wire logic next_ext = ext_low || ext_high;
    pfm_adc_s next_adc;
    always_comb begin
        next_adc.channel        = next_chan;
        next_adc.ref_bandgap    = n_ch[REF_SEL_BIT];
        next_adc.bandgap_level  = n_ch[1:0];
        next_adc.ext_valid      = next_ext;
        next_adc.bandgap        = next_chan == CH_BANDGAP;
        next_adc.ground         = next_chan == CH_GROUND;
        next_adc.supply_quarter = next_chan == CH_SUPPLY_4;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    localparam pfm_adc_s ADC_RESET = '{
        channel:        {RST_CHAN_SELECT[CHAN_TOP_BIT],
                         RST_CHAN_SELECT[CHAN_NIB_MSB:CHAN_NIB_LSB]},
        ref_bandgap:    RST_CHAN_SELECT[REF_SEL_BIT],
        bandgap_level:  RST_CHAN_SELECT[1:0],
        ext_valid:      1'b0,
        bandgap:        1'b0,
        ground:         1'b0,
        supply_quarter: 1'b1
    };

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            drive_out         <= '0;
            p1_mode_out       <= {RST_MODE_REG, RST_MODE_REG};
            p3_mode_out       <= {RST_MODE_REG, RST_MODE_REG};
            p0_din_enable_out <= RST_P0_IN_ENABLE;
            p0_analog_out     <= 8'h00;
            p1_analog_out     <= 8'h00;
            p3_analog_out     <= 8'h00;
            adc_out           <= ADC_RESET;
        end else begin
            drive_out         <= '{p0_en, p0_v, p1_en, p1_v, p3_en, p3_v};
            p1_mode_out       <= p1m;
            p3_mode_out       <= p3m;
            p0_din_enable_out <= n_die;
            p0_analog_out     <= next_p0_analog;
            p1_analog_out     <= next_p1_analog;
            p3_analog_out     <= next_p3_analog;
            adc_out           <= next_adc;
        end
    end

endmodule

/* bench/pfm_pins_model.sv */
// Model of the pins and peripheral sources around the pin mux
`timescale 1ns/10ps
module pfm_pins_model #(
    parameter logic [31:0] SEED = 32'h1d2c3b4a
) (
    input  wire logic  clk_in,
    output logic [6:0] pwm_out,
    output logic       neg_out,
    output logic       sda_o_out,
    output logic       scl_o_out,
    output logic       sda_oe_out,
    output logic       scl_oe_out
);
    logic [31:0] st = SEED;
    // Sources change every cycle, just after the edge
    always @(posedge clk_in) begin
        st <= {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
    end
    assign {scl_oe_out, sda_oe_out, scl_o_out, sda_o_out} = st[11:8];
    assign {neg_out, pwm_out} = st[7:0];
endmodule

/* bench/pfm_pin_mux_properties.sv */
// Port checks of the pin mux
`timescale 1ns/10ps
module pfm_pin_mux_properties
    import pfm_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire pfm_bus_s    bus_in,
    input wire logic [6:0]  pwm_in,
    input wire pfm_drive_s  drive_out,
    input wire logic [15:0] p1_mode_out,
    input wire logic [15:0] p3_mode_out,
    input wire logic [7:0]  p0_din_enable_out,
    input wire logic [7:0]  p0_analog_out,
    input wire logic [7:0]  p1_analog_out,
    input wire logic [7:0]  p3_analog_out,
    input wire pfm_adc_s    adc_out
);
    logic       wr_q;
    logic [7:0] wa_q;
    logic [7:0] wd_q;
    logic [7:0] p1_ana;
    logic [7:0] p3_ana;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge clk_in) begin
        wr_q <= rst_n_in && bus_in.wr;
        wa_q <= bus_in.addr;
        wd_q <= bus_in.wdata;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p1_ana[i] = p1_mode_out[2*i +: 2] == MODE_ANALOG;
            p3_ana[i] = p3_mode_out[2*i +: 2] == MODE_ANALOG;
        end
    end
    a_p1_low_write: assert property (
        wr_q && wa_q == ADDR_P1_MODE_LOW |-> p1_mode_out[7:0] == wd_q)
        else $error("port1 low modes not written");
    a_p3_high_write: assert property (
        wr_q && wa_q == ADDR_P3_MODE_HIGH |-> p3_mode_out[15:8] == wd_q)
        else $error("port3 high modes not written");
    a_mode_hold: assert property (
        !wr_q |-> $stable(p1_mode_out) && $stable(p3_mode_out))
        else $error("mode fields moved without a write");
    a_p1_analog_map: assert property (
        p1_analog_out == (p1_ana & 8'hfb))
        else $error("port1 analog map wrong");
    a_p3_analog_map: assert property (
        p3_analog_out == (p3_ana & 8'h1f))
        else $error("port3 analog map wrong");
    a_p0_analog_map: assert property (
        p0_analog_out == (~p0_din_enable_out & 8'hbf))
        else $error("port0 analog map wrong");
    a_chan_write: assert property (
        wr_q && wa_q == ADDR_CHAN_SELECT |-> adc_out.channel ==
        {wd_q[3], wd_q[7:4]} && adc_out.ref_bandgap == wd_q[2])
        else $error("channel select not applied");
    a_chan_internal: assert property (
        {adc_out.bandgap, adc_out.ground, adc_out.supply_quarter} ==
        {adc_out.channel == CH_BANDGAP, adc_out.channel == CH_GROUND,
         adc_out.channel == CH_SUPPLY_4})
        else $error("internal channel flags wrong");
    a_chan_external: assert property (
        adc_out.ext_valid == (adc_out.channel < 5'h0c ||
        (adc_out.channel >= 5'h10 && adc_out.channel <= 5'h16)))
        else $error("external channel flag wrong");
    a_route_p03: assert property (
        $past(rst_n_in) && $past(bus_in.wr) && $past(bus_in.wdata[0]) &&
        $past(bus_in.addr) == ADDR_PWM_ROUTE_A |-> drive_out.p0_en[3] &&
        drive_out.p0_val[3] == $past(pwm_in[0]))
        else $error("positive output not on port0 pin3");
endmodule

/* bench/pfm_pin_mux_tb.sv */
// Self-checking bench of the pin mux
`timescale 1ns/10ps
module pfm_pin_mux_tb;
    import pfm_pkg::*;
    localparam logic [7:0] ADDRS [10] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5,
        8'ha6, 8'hae, 8'haf, 8'hb6, 8'hb7, 8'ha7};
    localparam logic [31:0] ROUTES [28] = '{
        32'ha6800a01, 32'ha6400601, 32'ha6200401, 32'ha6100201,
        32'ha6081607, 32'ha6041500, 32'ha6020407, 32'ha6010300,
        32'hb6801604, 32'hb6400d04, 32'hb6200404, 32'hb6100004,
        32'hb6081403, 32'hb6040803, 32'hb6021602, 32'hb6010902,
        32'hb7e00b06, 32'hb7900706, 32'hb7880306, 32'hb7840c05,
        32'hb7820605, 32'hb7810105, 32'hb7800e08, 32'hb7400209,
        32'hb7001508, 32'hb7000b09, 32'ha6220407, 32'hb6821602};
    logic        clk_in;
    logic        rst_n_in;
    pfm_bus_s    bus;
    logic [7:0]  rdata;
    logic [6:0]  pwm;
    logic        neg, sda_o, scl_o, sda_oe, scl_oe;
    pfm_drive_s  drv;
    pfm_adc_s    adc;
    logic [15:0] p1m, p3m;
    logic [7:0]  p0de, p0a, p1a, p3a;
    logic [7:0]  shadow [256];
    logic        known [256];
    logic [7:0]  exp_q [$];
    logic        rd_q;
    logic [11:0] src_q;
    logic [31:0] seed;
    int          fails;
    int          samples_checked;

    pfm_pins_model pins_u (.clk_in(clk_in), .pwm_out(pwm), .neg_out(neg),
        .sda_o_out(sda_o), .scl_o_out(scl_o), .sda_oe_out(sda_oe),
        .scl_oe_out(scl_oe));
    pfm_pin_mux dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
        .rdata_out(rdata), .pwm_in(pwm), .pwm0_neg_in(neg),
        .i2c_sda_oe_in(sda_oe), .i2c_sda_o_in(sda_o),
        .i2c_scl_oe_in(scl_oe), .i2c_scl_o_in(scl_o), .drive_out(drv),
        .p1_mode_out(p1m), .p3_mode_out(p3m), .p0_din_enable_out(p0de),
        .p0_analog_out(p0a), .p1_analog_out(p1a), .p3_analog_out(p3a),
        .adc_out(adc));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= {a, d, 2'b10};
        if (known[a]) shadow[a] = d;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a);
        bus <= {a, 8'h00, 2'b01};
        exp_q.push_back(known[a] ? shadow[a] : 8'h00);
        @(posedge clk_in);
    endtask
    task automatic look;
        bus <= '0;
        @(negedge clk_in);
    endtask
    task automatic wrap_up;
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Clock, result watcher and watchdog
    // ----------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        rd_q <= bus.rd;
        src_q <= {scl_oe, sda_oe, scl_o, sda_o, neg, pwm};
    end
    always @(negedge clk_in) begin
        if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
    end
    initial begin
        #50us;
        fails++;
        wrap_up;
    end

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        logic [31:0] e;
        logic [23:0] en;
        logic [23:0] va;
        logic [7:0]  d;
        int          s;
        int          p;
        for (int i = 0; i < 256; i++) begin
            shadow[i] = 8'h00;
            known[i] = 1'b0;
        end
        for (int i = 0; i < 9; i++) known[ADDRS[i]] = 1'b1;
        for (int i = 0; i < 4; i++) shadow[ADDRS[i]] = 8'h55;
        shadow[8'hae] = 8'hf0;
        shadow[8'haf] = 8'hff;
        bus = '0;
        rst_n_in = 1'b0;
        seed = 32'hbc462522;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        chk("channel", 32'h0f, adc.channel);
        @(posedge clk_in);
        for (int i = 0; i < 10; i++) rd(ADDRS[i]);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            if (i == 5 && d[2]) d[1:0] = 2'h1;
            wr(ADDRS[i], d);
        end
        for (int i = 0; i < 10; i++) rd(ADDRS[i]);
        for (int c = 0; c < 32; c++) begin
            wr(8'hae, {c[3:0], c[4], c[0], 2'h1});
            look;
            chk("chan", c, adc.channel);
            chk("ext", (c < 12) || (c > 15 && c < 23), adc.ext_valid);
            chk("flags", {c == 12, c == 14, c == 15},
                {adc.bandgap, adc.ground, adc.supply_quarter});
            chk("ref", {c[0], 2'h1}, {adc.ref_bandgap, adc.bandgap_level});
            @(posedge clk_in);
        end
        for (int i = 0; i < 4; i++) wr(ADDRS[i], 8'hff);
        wr(8'haf, 8'h00);
        look;
        chk("p1_analog", 8'hfb, p1a);
        chk("p3_analog", 8'h1f, p3a);
        chk("p0_analog", 8'hbf, p0a);
        chk("p1_mode", 32'hffff, p1m);
        chk("p3_mode", 32'hffff, p3m);
        chk("p0_in_en", 32'h00, p0de);
        @(posedge clk_in);
        for (int i = 0; i < 28; i++) begin
            e = ROUTES[i];
            wr(8'ha6, 8'h00);
            wr(8'hb6, 8'h00);
            wr(8'hb7, 8'h80);
            wr(e[31:24], e[23:16]);
            look;
            en = {drv.p3_en, drv.p1_en, drv.p0_en};
            va = {drv.p3_val, drv.p1_val, drv.p0_val};
            s = e[3:0];
            p = e[12:8];
            chk("pin_en", s < 8 ? 1'b1 : src_q[s + 2], en[p]);
            if (s < 8 || src_q[s + 2]) chk("pin_val", src_q[s], va[p]);
            @(posedge clk_in);
        end
        rd(8'hb7);
        look;
        @(posedge clk_in);
        wrap_up;
    end
endmodule

bind pfm_pin_mux pfm_pin_mux_properties chk_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .bus_in(bus_in), .pwm_in(pwm_in),
    .drive_out(drive_out), .p1_mode_out(p1_mode_out),
    .p3_mode_out(p3_mode_out), .p0_din_enable_out(p0_din_enable_out),
    .p0_analog_out(p0_analog_out), .p1_analog_out(p1_analog_out),
    .p3_analog_out(p3_analog_out), .adc_out(adc_out));
